// *** hdl/rdf_filter.sv ***
// digital rc low-pass emulation followed by a hysteresis slicer
`timescale 1ns/1ps
module rdf_filter
    import rdf_pkg::*;
(
    input  wire logic bit_clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic demod,
    output logic      sliced
);

    logic [FILT_W-1:0] acc_r;
    logic [FILT_W-1:0] acc_nxt;
    logic              sliced_r;

    // ==================================================================
    // first order low-pass: move a fraction of the way to the target
    always_comb begin
        if (demod) begin
            acc_nxt = acc_r + ((FILT_FULL - acc_r) >> FILT_SHIFT);
        end else begin
            acc_nxt = acc_r - (acc_r >> FILT_SHIFT);
        end
    end

    // integrator state
    always_ff @(posedge bit_clk) begin
        if (!rst_n || !en) begin
            acc_r <= FILT_EMPTY;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // comparator with hysteresis: holds between the two thresholds
    always_ff @(posedge bit_clk) begin
        if (!rst_n || !en) begin
            sliced_r <= 1'b0;
        end else if (acc_r >= HYS_HI) begin
            sliced_r <= 1'b1;
        end else if (acc_r <= HYS_LO) begin
            sliced_r <= 1'b0;
        end
    end

    assign sliced = sliced_r;

endmodule

// *** hdl/rdf_pkg.sv ***
// shared constants and types for the receive data filter and bit timing recovery
package rdf_pkg;

    // ==================================================================
    // clock and reset timing
    localparam int unsigned REF_PERIOD_NS = 10;
    localparam int unsigned SOFT_RST_NS   = 250000;
    localparam int unsigned POR_NS        = 50000000;
    localparam int unsigned SOFT_RST_CYC  = SOFT_RST_NS / REF_PERIOD_NS;
    localparam int unsigned POR_CYC       = POR_NS / REF_PERIOD_NS;
    localparam int          RST_CNT_W     = 23;

    // ==================================================================
    // digital rc filter and hysteresis slicer
    localparam int          FILT_W     = 8;
    localparam int          FILT_SHIFT = 2;
    localparam logic [7:0]  FILT_FULL  = 8'hff;
    localparam logic [7:0]  FILT_EMPTY = 8'h00;
    localparam logic [7:0]  HYS_HI     = 8'hb0;
    localparam logic [7:0]  HYS_LO     = 8'h50;

    // ==================================================================
    // bit timing recovery, 16 samples per bit
    localparam int          OVS_W      = 4;
    localparam logic [3:0]  PH_STEP    = 4'h1;
    localparam logic [3:0]  PH_HALF    = 4'h8;
    localparam logic [3:0]  PH_ZERO    = 4'h0;
    localparam int          ERR_W      = 5;
    localparam logic signed [4:0] SLOW_WIN = 5'sh03;
    localparam logic signed [4:0] LOCK_WIN = 5'sh01;
    localparam int          FAST_SHIFT = 1;
    localparam int          SLOW_SHIFT = 2;
    localparam int          LOCK_CNT_W = 4;
    localparam logic [3:0]  LOCK_EDGES = 4'h8;
    localparam logic [3:0]  LOCK_STEP  = 4'h1;
    localparam logic [1:0]  CR_MODE_FAST = 2'h0;
    localparam logic [1:0]  CR_MODE_SLOW = 2'h1;
    localparam logic [1:0]  CR_MODE_AUTO = 2'h2;

    // ==================================================================
    // fifo fill accounting
    localparam int          FILL_W    = 7;
    localparam logic [6:0]  FIFO_BITS = 7'h40;
    localparam logic [6:0]  FILL_STEP = 7'h01;
    localparam logic [6:0]  FILL_ZERO = 7'h00;

    // ==================================================================
    // synchroniser lanes into the reference domain
    localparam int SY_ANA  = 0;
    localparam int SY_SEL  = 1;
    localparam int SY_FILT = 2;
    localparam int SY_RCLK = 3;
    localparam int SY_TGL  = 4;
    localparam int SY_LOCK = 5;
    localparam int SY_W    = 6;

    // ==================================================================
    // reset sequencing
    typedef enum logic [1:0] {
        RDF_ST_POR,
        RDF_ST_SOFT,
        RDF_ST_RUN
    } rdf_rst_state_t;

endpackage

// *** hdl/rdf_recovery.sv ***
// bit timing recovery: phase tracking with fast, slow and automatic settling
`timescale 1ns/1ps
module rdf_recovery
    import rdf_pkg::*;
(
    input  wire logic       bit_clk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic [1:0] mode,
    input  wire logic       data_in,
    output logic            sample_tgl,
    output logic            sample_bit,
    output logic            rec_clk,
    output logic            locked
);

    logic [OVS_W-1:0]        phase_r;
    logic [OVS_W-1:0]        phase_nxt;
    logic [LOCK_CNT_W-1:0]   lock_cnt_r;
    logic                    data_d_r;
    logic                    tgl_r;
    logic                    bit_r;
    logic                    clk_r;
    logic                    locked_r;
    logic                    edge_seen;
    logic                    slow_eff;
    logic                    accept;
    logic signed [ERR_W-1:0] err;
    logic signed [ERR_W-1:0] mag;
    logic signed [ERR_W-1:0] corr;

    // ==================================================================
    // phase error at each data transition, signed around the bit start
    always_comb begin
        edge_seen = data_in != data_d_r;
        err = (phase_r < PH_HALF) ? $signed({1'b0, phase_r}) : $signed({1'b1, phase_r});
        mag = (err < 0) ? -err : err;
        slow_eff = (mode == CR_MODE_SLOW) || ((mode != CR_MODE_FAST) && locked_r);
        accept = edge_seen && (!slow_eff || (mag <= SLOW_WIN));
        corr = slow_eff ? (err >>> SLOW_SHIFT) : (err >>> FAST_SHIFT);
        phase_nxt = phase_r + PH_STEP - (accept ? corr[OVS_W-1:0] : PH_ZERO);
    end

    // phase counter, sample point and recovered clock
    always_ff @(posedge bit_clk) begin
        if (!rst_n || !en) begin
            phase_r  <= PH_ZERO;
            data_d_r <= 1'b0;
            tgl_r    <= 1'b0;
            bit_r    <= 1'b0;
            clk_r    <= 1'b0;
        end else begin
            phase_r  <= phase_nxt;
            data_d_r <= data_in;
            clk_r    <= phase_nxt >= PH_HALF; // rises at mid-bit
            if (phase_r == PH_HALF) begin
                bit_r <= data_in;
                tgl_r <= ~tgl_r; // one event per recovered bit
            end
        end
    end

    // lock detector: consecutive transitions inside the lock window
    always_ff @(posedge bit_clk) begin
        if (!rst_n || !en) begin
            lock_cnt_r <= '0;
            locked_r   <= 1'b0;
        end else if (edge_seen) begin
            if (mag > LOCK_WIN) begin
                lock_cnt_r <= locked_r ? lock_cnt_r : '0;
            end else if (lock_cnt_r != LOCK_EDGES) begin
                lock_cnt_r <= lock_cnt_r + LOCK_STEP;
            end
            if ((mag <= LOCK_WIN) && (lock_cnt_r == LOCK_EDGES - LOCK_STEP)) begin
                locked_r <= 1'b1;
            end
        end
    end

    assign sample_tgl = tgl_r;
    assign sample_bit = bit_r;
    assign rec_clk    = clk_r;
    assign locked     = locked_r;

endmodule

// *** hdl/rdf_top.sv ***
// receive data filter, bit timing recovery and data/clock pin multiplexing
`timescale 1ns/1ps

// Contract
// - fifo off: data pin drives filtered data, clock pin drives recovered clock.
// - fifo on: data pin is active-low fifo select input, clock pin shows fill flag.
// - serial commands are ignored during the power-on reset interval.
// - after a software reset, hold off 0.25 ms before normal operation resumes.
// - analog filter mode: no fifo filling and no recovered clock.
// - analog filter mode carries data rates up to 256 kbps.
// - digital mode: rc low-pass emulation, then a comparator with hysteresis.
// - digital mode: recovered clock follows the bits and shifts them into the fifo.
// - recovery offers fast, slow and automatic settling.
// - slow mode settles slower and accepts less timing error than fast.
// - automatic mode starts fast and turns slow once locked.
// - only filter, recovery and their input synchronisers run on the bit-rate clock.
// - fifo on: raise fill flag and interrupt request at the programmed bit count.
module rdf_top
    import rdf_pkg::*;
#(
    parameter int unsigned POR_CYCLES  = POR_CYC,
    parameter int unsigned SOFT_CYCLES = SOFT_RST_CYC
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              bit_clk,
    input  wire logic              demod_in,
    input  wire logic              analog_slicer_in,
    input  wire logic              digital_filter_sel,
    input  wire logic              fifo_enable,
    input  wire logic [1:0]        cr_mode,
    input  wire logic [FILL_W-1:0] fill_level,
    input  wire logic              fill_flag_clear,
    input  wire logic              soft_reset,
    input  wire logic              cmd_valid,
    input  wire logic              data_pin_i,
    output logic                   data_pin_o,
    output logic                   data_pin_oe,
    output logic                   clk_pin_o,
    output logic                   fifo_fill_threshold_flag,
    output logic                   fill_irq_req,
    output logic                   fifo_access_grant,
    output logic                   fifo_push,
    output logic                   fifo_push_bit,
    output logic                   cmd_accept,
    output logic                   cmd_ready,
    output logic                   cr_locked
);

    // ==================================================================
    // reference domain declarations
    rdf_rst_state_t        state_r;
    rdf_rst_state_t        state_nxt;
    logic [RST_CNT_W-1:0]  rst_cnt_r;
    logic                  bit_rst_req_r;
    logic [SY_W-1:0]       sy1_r;
    logic [SY_W-1:0]       sy2_r;
    logic                  tgl_d_r;
    logic                  bit_evt;
    logic                  filt_data;
    logic                  fifo_on;
    logic [FILL_W-1:0]     fill_cnt_r;
    logic [FILL_W-1:0]     fill_cnt_inc;
    logic                  flag_r;
    logic                  flag_nxt;
    logic                  flag_set;
    logic                  data_pin_o_r;
    logic                  data_pin_oe_r;
    logic                  clk_pin_o_r;
    logic                  irq_r;
    logic                  grant_r;
    logic                  push_r;
    logic                  push_bit_r;
    logic                  accept_r;
    logic                  ready_r;
    logic                  locked_r;

    // ==================================================================
    // bit-rate domain declarations
    logic                  brst1_r;
    logic                  brst2_r;
    logic                  dem1_r;
    logic                  dem2_r;
    logic [2:0]            cfg1_r;
    logic [2:0]            cfg2_r;
    logic                  b_sliced;
    logic                  b_tgl;
    logic                  b_bit;
    logic                  b_rclk;
    logic                  b_locked;

    // ==================================================================
    // reset sequencing: power-on interval, then software reset holdoff
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RDF_ST_POR: begin
                if (rst_cnt_r == RST_CNT_W'(POR_CYCLES - 1)) begin
                    state_nxt = RDF_ST_RUN;
                end
            end
            RDF_ST_SOFT: begin
                if (rst_cnt_r == RST_CNT_W'(SOFT_CYCLES - 1)) begin
                    state_nxt = RDF_ST_RUN;
                end
            end
            RDF_ST_RUN: begin
                if (soft_reset) begin
                    state_nxt = RDF_ST_SOFT;
                end
            end
            default: begin
                state_nxt = RDF_ST_POR;
            end
        endcase
    end

    // state register and interval counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r   <= RDF_ST_POR;
            rst_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                rst_cnt_r <= '0;
            end else begin
                rst_cnt_r <= rst_cnt_r + RST_CNT_W'(1);
            end
        end
    end

    // command gate: refused until the reset intervals are over
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            accept_r <= 1'b0;
            ready_r  <= 1'b0;
        end else begin
            accept_r <= cmd_valid && (state_r == RDF_ST_RUN) && !soft_reset;
            ready_r  <= state_nxt == RDF_ST_RUN;
        end
    end

    // reset request toward the bit-rate domain
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_rst_req_r <= 1'b1;
        end else begin
            bit_rst_req_r <= state_r == RDF_ST_SOFT;
        end
    end

    // ==================================================================
    // bit-rate domain synchronisers
    always_ff @(posedge bit_clk) begin
        brst1_r <= bit_rst_req_r;
        brst2_r <= brst1_r;
        dem1_r  <= demod_in;
        dem2_r  <= dem1_r;
        cfg1_r  <= {cr_mode, digital_filter_sel};
        cfg2_r  <= cfg1_r;
    end

    // digital filter, only alive in digital mode
    rdf_filter u_filter (
        .bit_clk (bit_clk),
        .rst_n   (!brst2_r),
        .en      (cfg2_r[0]),
        .demod   (dem2_r),
        .sliced  (b_sliced)
    );

    // bit timing recovery on the filtered stream
    rdf_recovery u_recovery (
        .bit_clk    (bit_clk),
        .rst_n      (!brst2_r),
        .en         (cfg2_r[0]),
        .mode       (cfg2_r[2:1]),
        .data_in    (b_sliced),
        .sample_tgl (b_tgl),
        .sample_bit (b_bit),
        .rec_clk    (b_rclk),
        .locked     (b_locked)
    );

    // ==================================================================
    // two-stage synchronisers into the reference domain
    always_ff @(posedge ref_clk) begin
        sy1_r[SY_ANA]  <= analog_slicer_in;
        sy1_r[SY_SEL]  <= data_pin_i;
        sy1_r[SY_FILT] <= b_sliced;
        sy1_r[SY_RCLK] <= b_rclk;
        sy1_r[SY_TGL]  <= b_tgl;
        sy1_r[SY_LOCK] <= b_locked;
        sy2_r          <= sy1_r;
    end

    // toggle edge marks a recovered bit; its value is held long by then
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tgl_d_r <= 1'b0;
        end else begin
            tgl_d_r <= sy2_r[SY_TGL];
        end
    end

    // data source selection and fifo shift condition
    always_comb begin
        fifo_on   = fifo_enable && digital_filter_sel;
        filt_data = digital_filter_sel ? sy2_r[SY_FILT] : sy2_r[SY_ANA];
        bit_evt   = (tgl_d_r != sy2_r[SY_TGL]) && fifo_on && (state_r == RDF_ST_RUN);
    end

    // fifo shift strobe with the recovered bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            push_r     <= 1'b0;
            push_bit_r <= 1'b0;
        end else begin
            push_r <= bit_evt;
            if (bit_evt) begin
                push_bit_r <= b_bit;
            end
        end
    end

    // ==================================================================
    // fill threshold: a new bit setting the flag wins over a clear
    always_comb begin
        fill_cnt_inc = (fill_cnt_r == FIFO_BITS) ? fill_cnt_r : fill_cnt_r + FILL_STEP;
        if (fill_flag_clear) begin
            fill_cnt_inc = FILL_STEP;
        end
        flag_set = bit_evt && (fill_cnt_inc >= fill_level);
        if (!fifo_on || (state_r != RDF_ST_RUN)) begin
            flag_nxt = 1'b0;
        end else if (flag_set) begin
            flag_nxt = 1'b1;
        end else if (fill_flag_clear) begin
            flag_nxt = 1'b0;
        end else begin
            flag_nxt = flag_r;
        end
    end

    // bit counter since the last clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !fifo_on || (state_r != RDF_ST_RUN)) begin
            fill_cnt_r <= FILL_ZERO;
        end else if (bit_evt) begin
            fill_cnt_r <= fill_cnt_inc;
        end else if (fill_flag_clear) begin
            fill_cnt_r <= FILL_ZERO;
        end
    end

    // flag and interrupt request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            irq_r  <= flag_nxt;
        end
    end

    // ==================================================================
    // pin 6 and pin 7 multiplexing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_pin_oe_r <= 1'b0;
            data_pin_o_r  <= 1'b0;
            clk_pin_o_r   <= 1'b0;
            grant_r       <= 1'b0;
        end else if (fifo_enable) begin
            data_pin_oe_r <= 1'b0; // becomes the select input
            data_pin_o_r  <= 1'b0;
            clk_pin_o_r   <= flag_nxt;
            grant_r       <= !sy2_r[SY_SEL] && digital_filter_sel;
        end else begin
            data_pin_oe_r <= 1'b1;
            data_pin_o_r  <= filt_data;
            clk_pin_o_r   <= digital_filter_sel && sy2_r[SY_RCLK];
            grant_r       <= 1'b0;
        end
    end

    // lock status for software
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            locked_r <= 1'b0;
        end else begin
            locked_r <= digital_filter_sel && sy2_r[SY_LOCK];
        end
    end

    // ==================================================================
    // outputs, each straight from a flip-flop
    assign data_pin_o               = data_pin_o_r;
    assign data_pin_oe              = data_pin_oe_r;
    assign clk_pin_o                = clk_pin_o_r;
    assign fifo_fill_threshold_flag = flag_r;
    assign fill_irq_req             = irq_r;
    assign fifo_access_grant        = grant_r;
    assign fifo_push                = push_r;
    assign fifo_push_bit            = push_bit_r;
    assign cmd_accept               = accept_r;
    assign cmd_ready                = ready_r;
    assign cr_locked                = locked_r;

endmodule

// *** test/rdf_host_model.sv ***
// host model: fifo enable and fifo select on the data pin
`timescale 1ns/1ps
module rdf_host_model (
    input  wire logic ref_clk,
    input  wire logic want_fifo,
    input  wire logic flag_in,
    input  wire logic data_pin_o,
    input  wire logic data_pin_oe,
    output logic      fifo_enable,
    output logic      data_pin_i
);
    logic en_r    = 1'b0;
    logic sel_n_r = 1'b1;
    logic last_r  = 1'b0;

    // enable level, select on fill flag; undriven pin shows select while enabled, else inverse of last level
    always_ff @(posedge ref_clk) begin
        en_r    <= want_fifo;
        sel_n_r <= !(en_r && flag_in);
        last_r  <= data_pin_i;
    end
    assign fifo_enable = en_r;
    assign data_pin_i  = data_pin_oe ? data_pin_o : (en_r ? sel_n_r : !last_r);
endmodule

// *** test/rdf_top_sva.sv ***
// concurrent checks on the top module ports
`timescale 1ns/1ps
module rdf_top_sva
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic digital_filter_sel,
    input wire logic fifo_enable,
    input wire logic soft_reset,
    input wire logic cmd_valid,
    input wire logic data_pin_oe,
    input wire logic clk_pin_o,
    input wire logic fifo_fill_threshold_flag,
    input wire logic fill_irq_req,
    input wire logic fifo_access_grant,
    input wire logic fifo_push,
    input wire logic cmd_accept,
    input wire logic cmd_ready
);
    // ==================================================================
    // all checks run on the reference clock
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    cmd_take_a: assert property (cmd_valid && cmd_ready && !soft_reset |=> cmd_accept)
        else $error("no accept");
    cmd_gate_a: assert property (cmd_accept |-> $past(cmd_valid) && $past(cmd_ready))
        else $error("bad accept");
    soft_hold_a: assert property (cmd_ready && soft_reset |=> !cmd_ready [*8])
        else $error("hold short");
    pin_out_a: assert property (!fifo_enable [*2] |-> data_pin_oe)
        else $error("pin not driven");
    pin_in_a: assert property (fifo_enable [*2] |-> !data_pin_oe)
        else $error("pin driven");
    flag_pin_a: assert property (fifo_enable [*2] |-> clk_pin_o == fifo_fill_threshold_flag)
        else $error("flag not on pin");
    analog_clk_a: assert property ((!digital_filter_sel && !fifo_enable) [*2] |-> !clk_pin_o)
        else $error("analog clock");
    analog_push_a: assert property (!digital_filter_sel [*2] |-> !fifo_push && !fifo_fill_threshold_flag)
        else $error("analog fill");
    irq_flag_a: assert property (fill_irq_req == fifo_fill_threshold_flag)
        else $error("irq not flag");
    flag_rise_a: assert property ($rose(fifo_fill_threshold_flag) |-> fifo_push)
        else $error("flag without push");
    grant_off_a: assert property (!fifo_enable [*3] |-> !fifo_access_grant)
        else $error("grant off");
endmodule

bind rdf_top rdf_top_sva chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .digital_filter_sel(digital_filter_sel), .fifo_enable(fifo_enable),
    .soft_reset(soft_reset), .cmd_valid(cmd_valid), .data_pin_oe(data_pin_oe), .clk_pin_o(clk_pin_o),
    .fifo_fill_threshold_flag(fifo_fill_threshold_flag), .fill_irq_req(fill_irq_req),
    .fifo_access_grant(fifo_access_grant), .fifo_push(fifo_push), .cmd_accept(cmd_accept),
    .cmd_ready(cmd_ready)
);

// *** test/rx_data_filter_clock_recovery_tb.sv ***
// bench for the receive filter, recovery and pin mux
`timescale 1ns/1ps
module rx_data_filter_clock_recovery_tb
    import rdf_pkg::*;
;
    typedef struct {logic dig, fe, rs; logic [1:0] md; int len, rlo, rhi, plo, phi; logic lk;} rdf_row_t;
    localparam logic [31:0] PAT = 32'hb38f_0f1c;

    logic             ref_clk = 1'b0;
    logic             bit_clk = 1'b0;
    logic             bclk_run = 1'b1;
    logic             rst_n = 1'b0;
    logic             demod_in = 1'b0;
    logic             analog_slicer_in = 1'b0;
    logic             digital_filter_sel = 1'b0;
    logic             want_fifo = 1'b0;
    logic [1:0]       cr_mode = CR_MODE_FAST;
    logic [FILL_W-1:0] fill_level = 7'h40;
    logic             fill_flag_clear = 1'b0;
    logic             soft_reset = 1'b0;
    logic             cmd_valid = 1'b0;
    logic             fifo_enable, data_pin_i, data_pin_o, data_pin_oe, clk_pin_o, flag, irq, grant;
    logic             fifo_push, push_bit, cmd_accept, cmd_ready, cr_locked, last_clk;
    int               bad_count = 0;
    int               n_checks = 0;
    int               cyc = 0, push_cnt = 0, rise_cnt = 0, acc_cnt = 0, n = 0, one_cnt = 0;
    rdf_row_t         rows [5] = '{
        '{1'b0, 1'b0, 1'b1, CR_MODE_FAST, 390, 0, 0, 0, 0, 1'b0},
        '{1'b1, 1'b0, 1'b1, CR_MODE_FAST, 51, 32, 49, 0, 0, 1'b1},
        '{1'b1, 1'b0, 1'b0, CR_MODE_SLOW, 51, 40, 49, 0, 0, 1'b1},
        '{1'b1, 1'b0, 1'b1, CR_MODE_AUTO, 51, 32, 49, 0, 0, 1'b1},
        '{1'b1, 1'b1, 1'b0, CR_MODE_FAST, 51, 0, 1, 40, 49, 1'b1}};

    // ==================================================================
    // clocks, design and host
    always #5 ref_clk = ~ref_clk;
    always #16 bit_clk = bclk_run ? ~bit_clk : bit_clk;
    rdf_top #(.POR_CYCLES(20), .SOFT_CYCLES(10)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .bit_clk(bit_clk), .demod_in(demod_in),
        .analog_slicer_in(analog_slicer_in), .digital_filter_sel(digital_filter_sel), .fifo_enable(fifo_enable),
        .cr_mode(cr_mode), .fill_level(fill_level), .fill_flag_clear(fill_flag_clear), .soft_reset(soft_reset),
        .cmd_valid(cmd_valid), .data_pin_i(data_pin_i), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe),
        .clk_pin_o(clk_pin_o), .fifo_fill_threshold_flag(flag), .fill_irq_req(irq), .fifo_access_grant(grant),
        .fifo_push(fifo_push), .fifo_push_bit(push_bit), .cmd_accept(cmd_accept), .cmd_ready(cmd_ready),
        .cr_locked(cr_locked));
    rdf_host_model host_u (.ref_clk(ref_clk), .want_fifo(want_fifo), .flag_in(clk_pin_o), .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe), .fifo_enable(fifo_enable), .data_pin_i(data_pin_i));

    // ==================================================================
    // counters and timeout on the falling edge
    always @(negedge ref_clk) begin
        cyc++;
        if (fifo_push === 1'b1) push_cnt++;
        if (fifo_push === 1'b1 && push_bit === 1'b1) one_cnt++;
        if (clk_pin_o === 1'b1 && last_clk !== 1'b1) rise_cnt++;
        if (cmd_accept === 1'b1) acc_cnt++;
        last_clk = clk_pin_o;
        if (cyc == 60000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ==================================================================
    // shared tasks
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic chk_bit(input logic act, input logic exp, input string what);
        n_checks++;
        if (act !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_rng(input int act, input int lo, input int hi, input string what);
        n_checks++;
        if (act < lo || act > hi) begin
            bad_count++;
            $display("wrong value at %0t: %s %0d", $time, what, act);
        end
    endtask
    task automatic send_bits(input int nb, input int len, input logic ana);
        push_cnt = 0;
        rise_cnt = 0;
        one_cnt = 0;
        for (int i = 0; i < nb; i++) begin
            demod_in         <= PAT[i % 32];
            analog_slicer_in <= PAT[i % 32];
            tick(len - 1);
            #1;
            if (ana) chk_bit(data_pin_o, PAT[i % 32], "analog data");
            @(posedge ref_clk);
        end
    endtask
    task automatic wait_ready(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
            #1;
        end while (cmd_ready !== 1'b1 && k < 100);
        @(posedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==================================================================
    // main sequence
    initial begin
        tick(3);
        rst_n <= 1'b1;
        tick(1);
        #1 chk_bit(cmd_ready, 1'b0, "ready in por");
        tick(1);
        cmd_valid <= 1'b1;
        tick(5);
        cmd_valid <= 1'b0;
        wait_ready(n);
        cmd_valid <= 1'b1;
        tick(2);
        cmd_valid <= 1'b0;
        tick(3);
        #1 chk_rng(acc_cnt, 2, 2, "accepts");
        $display("power-on done");
        foreach (rows[i]) begin
            tick(1);
            bclk_run <= rows[i].dig;
            if (rows[i].rs) begin
                digital_filter_sel <= 1'b0;
                tick(10);
            end
            cr_mode   <= rows[i].md;
            want_fifo <= rows[i].fe;
            tick(1);
            digital_filter_sel <= rows[i].dig;
            tick(10);
            send_bits(48, rows[i].len, !rows[i].dig);
            #1 chk_rng(rise_cnt, rows[i].rlo, rows[i].rhi, "clock edges");
            chk_rng(push_cnt, rows[i].plo, rows[i].phi, "pushes");
            chk_bit(cr_locked, rows[i].lk, "lock");
            $display("row %0d done", i);
        end
        chk_rng(one_cnt, 14, 26, "pushed ones");
        tick(1);
        fill_level      <= 7'h08;
        fill_flag_clear <= 1'b1;
        tick(1);
        fill_flag_clear <= 1'b0;
        send_bits(12, 51, 1'b0);
        #1 chk_bit(flag, 1'b1, "fill flag");
        chk_bit(irq, 1'b1, "fill irq");
        chk_bit(clk_pin_o, 1'b1, "flag pin");
        chk_bit(grant, 1'b1, "grant");
        tick(1);
        fill_level      <= 7'h40;
        fill_flag_clear <= 1'b1;
        tick(1);
        fill_flag_clear <= 1'b0;
        tick(10);
        #1 chk_bit(flag, 1'b0, "flag clear");
        chk_bit(grant, 1'b0, "grant off");
        $display("fill done");
        tick(1);
        soft_reset <= 1'b1;
        tick(1);
        soft_reset <= 1'b0;
        cmd_valid  <= 1'b1;
        acc_cnt = 0;
        tick(3);
        cmd_valid <= 1'b0;
        wait_ready(n);
        #1 chk_rng(n + 3, 7, 12, "soft hold");
        chk_rng(acc_cnt, 0, 0, "soft accepts");
        $display("soft reset done");
        tally_and_finish();
    end
endmodule
